// file: hdl/mtc_core.v
// Purpose: 16-bit modulo up-counter timer with six channels on Avalon-MM
// Assumes: one clock clk_in; pins and mode inputs synchronous to it
// Notes:   read side effects at the accept edge, writes at the release edge
//
// Behaviour
// RL1: counter at period sets flag, restarts zero
// RL2: flag clears by read-set then zero write
// RL3: writing one keeps flag; reset clears it
// RL4: overflow request when flag and enable set
// RL5: channel event sets flag; enable gates request
// RL6: halt bit freezes counter; reset sets it
// RL7: halt blocks input captures
// RL8: clear bit zeroes counter and prescaler, self-clears
// RL9: halt plus clear leaves counter at zero
// RL10: clock select: divided bus clock or pin
// RL11: external clock kept below bus rate half
// RL12: selected clock pin forced to input
// RL13: high read latches low byte until read
// RL14: period high write suppresses overflow until low
// RL15: reset sets both period bytes
// RL16: software clears counter before period writes
// RL17: wait mode: runs, no access, requests wake
// RL18: stop mode freezes timer, keeps state
// RL19: break halts counter and blocks captures
// RL20: break protects flags unless clear enable
// RL21: six channels, even ones bufferable
// RL22: channel flag clears by read then zero
// RL23: everything on bus clock, pin edge detected
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "mtc_consts.vh"

module mtc_core #(
  parameter CH_N = 6
) (
  input  wire          clk_in,
  input  wire          rst_b_in,
  input  wire [7:0]    avs_address_in,
  input  wire          avs_read_in,
  input  wire          avs_write_in,
  input  wire [31:0]   avs_writedata_in,
  input  wire [3:0]    avs_byteenable_in,
  output wire [31:0]   avs_readdata_out,
  output wire          avs_waitrequest_out,
  input  wire          ext_count_clock_in,
  input  wire [CH_N-1:0] channel_pin_in,
  output wire [CH_N-1:0] channel_pin_out,
  output wire [CH_N-1:0] channel_pin_oe_out,
  output wire          ext_clock_is_input_out,
  input  wire          wait_mode_in,
  input  wire          stop_mode_in,
  input  wire          break_in,
  output wire          overflow_irq_out,
  output wire [CH_N-1:0] channel_irq_out,
  output wire          wake_out
);

  function match;
    input [7:0] a;
    input [7:0] off;
    begin
      match = (a[7:2] == off[7:2]);
    end
  endfunction

  // prescaler bits that must all be one for a tick
  function [6:0] div_mask;
    input [2:0] ps;
    begin
      case (ps)
        3'h0:    div_mask = 7'h00;
        3'h1:    div_mask = 7'h01;
        3'h2:    div_mask = 7'h03;
        3'h3:    div_mask = 7'h07;
        3'h4:    div_mask = 7'h0f;
        3'h5:    div_mask = 7'h1f;
        3'h6:    div_mask = 7'h3f;
        default: div_mask = 7'h7f;
      endcase
    end
  endfunction

  reg          wait_q;
  reg  [31:0]  rdata_q;
  reg  [7:0]   rmux;
  reg          ovf_q;
  reg          ovf_ie_q;
  reg          halt_q;
  reg  [2:0]   ps_q;
  reg          ovf_arm_q;
  reg  [15:0]  cnt_q;
  reg  [6:0]   presc_q;
  reg  [15:0]  per_q;
  reg          per_inh_q;
  reg  [7:0]   lo_latch_q;
  reg          latched_q;
  reg          bce_q;
  reg          ext_s1_q;
  reg          ext_s2_q;
  reg          ext_s3_q;
  reg          ovf_irq_q;
  reg  [CH_N-1:0] ch_irq_q;
  reg          wake_q;
  reg          ext_in_q;

  wire [8*CH_N-1:0]  ch_ctl_w;
  wire [16*CH_N-1:0] ch_val_w;
  wire [CH_N-1:0]    ch_msb_w;
  wire [CH_N-1:0]    ch_out_w;
  wire [CH_N-1:0]    ch_oe_w;

  // wait mode completes accesses with no effect and zero read data
  wire req      = (avs_read_in | avs_write_in) & ~wait_mode_in; // RL17
  wire rd_acc   = avs_read_in & wait_q & ~wait_mode_in;
  wire wr_go    = avs_write_in & ~wait_q & ~wait_mode_in;
  wire wr_b0    = wr_go & avs_byteenable_in[0];
  wire [7:0] wd = avs_writedata_in[7:0];
  wire brk_lock = break_in & ~bce_q; // RL20

  wire wr_ctrl  = wr_b0 & match(avs_address_in, `MTC_OFF_CTRL);
  wire rd_ctrl  = rd_acc & match(avs_address_in, `MTC_OFF_CTRL);
  wire clr_wr   = wr_ctrl & wd[`MTC_B_CLEAR];

  // timer clock: divided bus clock or edge of the pin
  wire ext_rise = ext_s2_q & ~ext_s3_q; // RL23
  wire tick     = (ps_q == `MTC_PS_EXT) ? ext_rise :
                  ((presc_q & div_mask(ps_q)) == div_mask(ps_q)); // RL10
  wire run      = ~halt_q & ~break_in & ~stop_mode_in; // RL6 RL18 RL19
  wire at_per   = (cnt_q == per_q);
  wire ovf_ev   = run & tick & at_per & ~clr_wr;
  wire ovf_set  = ovf_ev & ~per_inh_q; // RL14

  assign avs_waitrequest_out    = wait_q;
  assign avs_readdata_out       = rdata_q;
  assign overflow_irq_out       = ovf_irq_q;
  assign channel_irq_out        = ch_irq_q;
  assign wake_out               = wake_q;
  assign ext_clock_is_input_out = ext_in_q;

  // one wait cycle: data stands from the accept edge onward
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((avs_read_in | avs_write_in) & wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= {24'h00_0000, (req ? rmux : 8'h00)};
    end else begin
      wait_q  <= 1'b1;
    end
  end

  integer k, n;
  always @* begin
    rmux = 8'h00;
    if (match(avs_address_in, `MTC_OFF_CTRL))
      rmux = {ovf_q, ovf_ie_q, halt_q, 2'b00, ps_q}; // RL8
    else if (match(avs_address_in, `MTC_OFF_CNT_HI))
      rmux = cnt_q[15:8];
    else if (match(avs_address_in, `MTC_OFF_CNT_LO))
      rmux = latched_q ? lo_latch_q : cnt_q[7:0]; // RL13
    else if (match(avs_address_in, `MTC_OFF_PER_HI))
      rmux = per_q[15:8];
    else if (match(avs_address_in, `MTC_OFF_PER_LO))
      rmux = per_q[7:0];
    else if (match(avs_address_in, `MTC_OFF_BRK))
      rmux = {7'h00, bce_q};
    for (k = 0; k < CH_N; k = k + 1) begin
      if (match(avs_address_in, `MTC_OFF_CH_CTL + k[7:0] * `MTC_CH_CTL_STEP))
        rmux = ch_ctl_w[8*k +: 8];
      if (match(avs_address_in, `MTC_OFF_CH_VHI + k[7:0] * `MTC_CH_VAL_STEP))
        rmux = ch_val_w[16*k+8 +: 8];
      if (match(avs_address_in, `MTC_OFF_CH_VLO + k[7:0] * `MTC_CH_VAL_STEP))
        rmux = ch_val_w[16*k +: 8];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ovf_ie_q <= 1'b0; // RL4
      halt_q   <= 1'b1; // RL6
      ps_q     <= 3'h0; // RL10
      bce_q    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ovf_ie_q <= wd[`MTC_B_OVF_IE];
        halt_q   <= wd[`MTC_B_HALT];
        ps_q     <= wd[`MTC_F_PS_HI:`MTC_F_PS_LO];
      end
      if (wr_b0 & match(avs_address_in, `MTC_OFF_BRK))
        bce_q <= wd[0];
    end
  end

  // overflow flag: set wins over a clear in the same cycle
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ovf_q     <= 1'b0; // RL3
      ovf_arm_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q     <= 1'b1; // RL1
      ovf_arm_q <= 1'b0; // RL2
    end else if (brk_lock) begin
      ovf_q     <= ovf_q; // RL20
    end else if (rd_ctrl & ovf_q) begin
      ovf_arm_q <= 1'b1; // RL2
    end else if (wr_ctrl & ~wd[`MTC_B_OVF] & ovf_arm_q) begin
      ovf_q     <= 1'b0; // RL2 RL3
      ovf_arm_q <= 1'b0;
    end
  end

  // counter and prescaler
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q   <= `MTC_CNT_RST; // RL13
      presc_q <= 7'h00;
    end else if (clr_wr) begin
      cnt_q   <= `MTC_CNT_RST; // RL8 RL9
      presc_q <= 7'h00; // RL8
    end else if (run) begin
      presc_q <= presc_q + 7'h01;
      if (tick)
        cnt_q <= at_per ? `MTC_CNT_RST : cnt_q + 16'h0001; // RL1
    end
  end

  // pin synchroniser; the second and third stages feed the edge detector
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (~stop_mode_in) begin
      ext_s1_q <= ext_count_clock_in; // RL23
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q; // RL11
    end
  end

  // period registers and low-byte latch of the counter
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      per_q      <= `MTC_PERIOD_RST; // RL15
      per_inh_q  <= 1'b0;
      lo_latch_q <= 8'h00;
      latched_q  <= 1'b0;
    end else begin
      if (wr_b0 & match(avs_address_in, `MTC_OFF_PER_HI)) begin
        per_q[15:8] <= wd;
        per_inh_q   <= 1'b1; // RL14
      end
      if (wr_b0 & match(avs_address_in, `MTC_OFF_PER_LO)) begin
        per_q[7:0] <= wd;
        per_inh_q  <= 1'b0; // RL14
      end
      if (clr_wr)
        latched_q <= 1'b0;
      else if (rd_acc & match(avs_address_in, `MTC_OFF_CNT_HI) & ~latched_q) begin
        lo_latch_q <= cnt_q[7:0]; // RL13
        latched_q  <= 1'b1;
      end else if (rd_acc & match(avs_address_in, `MTC_OFF_CNT_LO))
        latched_q <= 1'b0; // RL13
    end
  end

  // request lines, all registered
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ovf_irq_q <= 1'b0;
      ch_irq_q  <= {CH_N{1'b0}};
      wake_q    <= 1'b0;
      ext_in_q  <= 1'b0;
    end else begin
      ovf_irq_q <= ovf_q & ovf_ie_q; // RL4
      for (n = 0; n < CH_N; n = n + 1)
        ch_irq_q[n] <= ch_ctl_w[8*n+`MTC_B_CH_FLAG] & ch_ctl_w[8*n+`MTC_B_CH_IE]; // RL5
      wake_q    <= wait_mode_in & ((ovf_q & ovf_ie_q) | (|ch_irq_q)); // RL17
      ext_in_q  <= (ps_q == `MTC_PS_EXT); // RL12
    end
  end

  genvar i;
  generate
    for (i = 0; i < CH_N; i = i + 1) begin : g_ch // RL21
      reg  [7:0]  ctl_q;
      reg  [15:0] val_q;
      reg         arm_q;
      reg         out_q;
      reg         oe_q;
      reg         pin_q;
      reg         sel_q;
      reg         pend_q;
      reg         cap_inh_q;
      reg         cmp_inh_q;
      wire [31:0] a_ctl = `MTC_OFF_CH_CTL + i * `MTC_CH_CTL_STEP;
      wire [31:0] a_vhi = `MTC_OFF_CH_VHI + i * `MTC_CH_VAL_STEP;
      wire [31:0] a_vlo = `MTC_OFF_CH_VLO + i * `MTC_CH_VAL_STEP;
      wire [31:0] a_phi = `MTC_OFF_CH_VHI + (i ^ 1) * `MTC_CH_VAL_STEP;
      wire [31:0] a_plo = `MTC_OFF_CH_VLO + (i ^ 1) * `MTC_CH_VAL_STEP;
      wire       odd   = (i % 2) == 1;
      // odd channel is swallowed by its buffered even partner
      wire       dis   = odd & ch_msb_w[i ^ 1];
      wire [1:0] els   = ctl_q[`MTC_F_ELS_HI:`MTC_F_ELS_LO];
      wire       on    = (els != 2'h0) & ~dis;
      wire       cap_m = on & ~ctl_q[`MTC_B_CH_MSB] & ~ctl_q[`MTC_B_CH_MSA];
      wire       cmp_m = on & (ctl_q[`MTC_B_CH_MSB] | ctl_q[`MTC_B_CH_MSA]);
      wire       rise  = channel_pin_in[i] & ~pin_q;
      wire       fall  = ~channel_pin_in[i] & pin_q;
      wire       hit   = (els[0] & rise) | (els[1] & fall);
      wire [15:0] cmpv = (ctl_q[`MTC_B_CH_MSB] & sel_q) ? ch_val_w[16*(i^1) +: 16] : val_q;
      wire cap_ev = cap_m & hit & run & ~cap_inh_q; // RL7 RL19
      wire cmp_ev = cmp_m & run & tick & (cnt_q == cmpv) & ~cmp_inh_q;
      wire ev     = cap_ev | cmp_ev; // RL5
      wire w_ctl  = wr_b0 & match(avs_address_in, a_ctl[7:0]);
      wire w_vhi  = wr_b0 & match(avs_address_in, a_vhi[7:0]);
      wire w_vlo  = wr_b0 & match(avs_address_in, a_vlo[7:0]);
      wire w_pair = wr_b0 & ~odd &
                    (match(avs_address_in, a_phi[7:0]) | match(avs_address_in, a_plo[7:0]));

      assign ch_ctl_w[8*i +: 8]  = ctl_q;
      assign ch_val_w[16*i +: 16] = val_q;
      assign ch_msb_w[i] = ctl_q[`MTC_B_CH_MSB];
      assign channel_pin_out[i]    = out_q;
      assign channel_pin_oe_out[i] = oe_q;

      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          ctl_q <= 8'h00;
          arm_q <= 1'b0;
        end else begin
          if (w_ctl) begin
            ctl_q[6:0] <= {wd[6], wd[5] & ~odd, wd[4:0]};
          end
          if (ev & ~dis) begin
            ctl_q[`MTC_B_CH_FLAG] <= 1'b1; // RL5
            arm_q <= 1'b0; // RL22
          end else if (brk_lock) begin
            arm_q <= arm_q; // RL20
          end else if (rd_acc & match(avs_address_in, a_ctl[7:0]) & ctl_q[`MTC_B_CH_FLAG]) begin
            arm_q <= 1'b1; // RL22
          end else if (w_ctl & ~wd[`MTC_B_CH_FLAG] & arm_q) begin
            ctl_q[`MTC_B_CH_FLAG] <= 1'b0; // RL22
            arm_q <= 1'b0;
          end
        end
      end

      // value register: capture beats a software write
      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          val_q     <= 16'h0000;
          cap_inh_q <= 1'b0;
          cmp_inh_q <= 1'b0;
          pin_q     <= 1'b0;
        end else begin
          if (~stop_mode_in)
            pin_q <= channel_pin_in[i];
          if (cap_ev)
            val_q <= cnt_q; // RL5
          else if (w_vhi)
            val_q[15:8] <= wd;
          else if (w_vlo)
            val_q[7:0] <= wd;
          // high-byte access blocks the channel until the low byte
          if (rd_acc & match(avs_address_in, a_vhi[7:0]) & cap_m)
            cap_inh_q <= 1'b1;
          else if (rd_acc & match(avs_address_in, a_vlo[7:0]))
            cap_inh_q <= 1'b0;
          if (w_vhi & ~cap_m)
            cmp_inh_q <= 1'b1;
          else if (w_vlo)
            cmp_inh_q <= 1'b0;
        end
      end

      // pin drive; overflow toggle takes precedence over compare
      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          out_q  <= 1'b1;
          oe_q   <= 1'b0;
          sel_q  <= 1'b0;
          pend_q <= 1'b0;
        end else begin
          oe_q <= cmp_m;
          if (w_vhi | w_vlo)
            pend_q <= 1'b0;
          else if (w_pair)
            pend_q <= 1'b1; // RL21
          if (ovf_ev)
            sel_q <= pend_q;
          if (els == 2'h0 || dis)
            out_q <= ~ctl_q[`MTC_B_CH_MSA];
          else if (cmp_m) begin
            if (ctl_q[`MTC_B_CH_TOV] & ctl_q[`MTC_B_CH_MAX])
              out_q <= 1'b1;
            else if (ovf_ev & ctl_q[`MTC_B_CH_TOV])
              out_q <= ~out_q;
            else if (cmp_ev) begin
              case (els)
                `MTC_ELS_TOGGLE: out_q <= ~out_q;
                `MTC_ELS_CLEAR:  out_q <= 1'b0;
                `MTC_ELS_SET:    out_q <= 1'b1;
                default:         out_q <= out_q;
              endcase
            end
          end
        end
      end
    end
  endgenerate

endmodule

// file: hdl/mtc_consts.vh
// Purpose: constants for the modulo timer core
// Assumes: byte addresses on the Avalon bus, one 32-bit word per register
// Notes:   8-bit registers sit in the low byte, upper bits read as zero
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH

// register byte offsets
`define MTC_OFF_CTRL     8'h00
`define MTC_OFF_CNT_HI   8'h04
`define MTC_OFF_CNT_LO   8'h08
`define MTC_OFF_PER_HI   8'h0c
`define MTC_OFF_PER_LO   8'h10
`define MTC_OFF_BRK      8'h14
`define MTC_OFF_CH_CTL   8'h20
`define MTC_OFF_CH_VHI   8'h40
`define MTC_OFF_CH_VLO   8'h44
`define MTC_CH_CTL_STEP  8'h04
`define MTC_CH_VAL_STEP  8'h08

// control/status fields
`define MTC_B_OVF        7
`define MTC_B_OVF_IE     6
`define MTC_B_HALT       5
`define MTC_B_CLEAR      4
`define MTC_F_PS_HI      2
`define MTC_F_PS_LO      0
`define MTC_PS_EXT       3'h7
`define MTC_CTRL_RST     8'h20

// channel control fields
`define MTC_B_CH_FLAG    7
`define MTC_B_CH_IE      6
`define MTC_B_CH_MSB     5
`define MTC_B_CH_MSA     4
`define MTC_F_ELS_HI     3
`define MTC_F_ELS_LO     2
`define MTC_B_CH_TOV     1
`define MTC_B_CH_MAX     0
`define MTC_ELS_TOGGLE   2'h1
`define MTC_ELS_CLEAR    2'h2
`define MTC_ELS_SET      2'h3

// reset values
`define MTC_PERIOD_RST   16'hffff
`define MTC_CNT_RST      16'h0000

`endif

// file: test/mtc_core_monitor.sv
// Purpose: port relations of the timer core
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module mtc_core_monitor #(
  parameter CH_N = 6
) (
  input wire            clk_in,
  input wire            rst_b_in,
  input wire [7:0]      avs_address_in,
  input wire            avs_read_in,
  input wire            avs_write_in,
  input wire [31:0]     avs_writedata_in,
  input wire [3:0]      avs_byteenable_in,
  input wire [31:0]     avs_readdata_out,
  input wire            avs_waitrequest_out,
  input wire            wait_mode_in,
  input wire            ext_clock_is_input_out,
  input wire            overflow_irq_out,
  input wire [CH_N-1:0] channel_irq_out,
  input wire            wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // write taking effect at this edge
  wire wr_now = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] && !wait_mode_in;
  wire ctl_wr = wr_now && avs_address_in[7:2] == 6'h00;
  wire ch0_wr = wr_now && avs_address_in[7:2] == 6'h08;

  chk_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for two cycles");
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered");
  chk_reset_quiet: assert property ($rose(rst_b_in) |-> !overflow_irq_out &&
    channel_irq_out == '0 && !wake_out && !ext_clock_is_input_out)
    else $error("outputs not quiet after reset");
  chk_wait_zero: assert property (avs_read_in && avs_waitrequest_out && wait_mode_in
    |=> avs_readdata_out == 32'h0) else $error("register readable in wait mode");
  chk_wake_gate: assert property (!wait_mode_in |=> !wake_out)
    else $error("wake outside wait mode");
  chk_wake_ovf: assert property (wait_mode_in && overflow_irq_out |-> ##[1:2] wake_out)
    else $error("enabled request did not wake");
  chk_ext_sel: assert property (ctl_wr && avs_writedata_in[2:0] == 3'h7
    |-> ##[1:2] ext_clock_is_input_out) else $error("count pin not forced input");
  chk_ext_off: assert property (ctl_wr && avs_writedata_in[2:0] != 3'h7
    |-> ##[1:2] !ext_clock_is_input_out) else $error("count pin held as input");
  chk_irq_mask: assert property (ctl_wr && !avs_writedata_in[6]
    |-> ##[1:3] !overflow_irq_out) else $error("overflow request not masked");
  chk_ch_mask: assert property (ch0_wr && !avs_writedata_in[6]
    |-> ##[1:3] !channel_irq_out[0]) else $error("channel request not masked");
endmodule

// file: test/mtc_pin_model.sv
// Purpose: far side pins: count clock and channel inputs
// Assumes: paced from the bus clock
// Notes:   count clock stands low between bursts
`timescale 1ns/10ps
module mtc_pin_model (
  input  wire       clk_in,
  output reg        ext_clk_out,
  output reg  [5:0] pin_out
);
  initial begin
    ext_clk_out = 1'b0;
    pin_out     = 6'h00;
  end
  // seven bus clocks a period keeps below 4 MHz and half the bus rate
  task pulse_ext(input int n);
    repeat (n) begin
      @(posedge clk_in) ext_clk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      ext_clk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
  task pulse_pin(input int i);
    @(posedge clk_in) pin_out[i] <= 1'b1;
    repeat (4) @(posedge clk_in);
    pin_out[i] <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// file: test/mtc_core_bench.sv
// Purpose: self-checking bench of the timer core
// Assumes: Avalon master with one request at a time
// Notes:   counts checked with a small tolerance for tick latency
`timescale 1ns/10ps
`include "mtc_consts.vh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module mtc_core_bench;
  logic        clk_in = 1'b0, rst_b_in = 1'b0;
  logic        rd = 1'b0, wt = 1'b0, wmode = 1'b0, smode = 1'b0, brk = 1'b0;
  logic [7:0]  adr = 8'h00, q, a;
  logic [31:0] wdat = 32'h0, rdata, seed = 32'h462e4768;
  logic [15:0] v, p, per;
  logic [5:0]  pins, pout, poe, ch_irq, ch_in;
  logic        wreq, ext, ext_in, ovf_irq, wake;
  int          mismatches = 0, checked = 0, w;
  int          model_q[$];

  always #25 clk_in = ~clk_in;
  assign ch_in = (poe & pout) | (~poe & pins);

  mtc_pin_model u_mtc_pin_model (.clk_in(clk_in), .ext_clk_out(ext), .pin_out(pins));
  mtc_core #(.CH_N(6)) u_mtc_core (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wt), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .ext_count_clock_in(ext), .channel_pin_in(ch_in), .channel_pin_out(pout),
    .channel_pin_oe_out(poe), .ext_clock_is_input_out(ext_in), .wait_mode_in(wmode),
    .stop_mode_in(smode), .break_in(brk), .overflow_irq_out(ovf_irq),
    .channel_irq_out(ch_irq), .wake_out(wake));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic acc(input logic wr, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    adr  <= ad;
    wdat <= {24'h0, d};
    rd   <= !wr;
    wt   <= wr;
    do @(posedge clk_in); while (wreq !== 1'b0);
    q  = rdata[7:0];
    rd <= 1'b0;
    wt <= 1'b0;
  endtask

  task automatic cnt(output logic [15:0] c);
    acc(1'b0, `MTC_OFF_CNT_HI, 8'h00);
    c[15:8] = q;
    acc(1'b0, `MTC_OFF_CNT_LO, 8'h00);
    c[7:0] = q;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    model_q = '{32'h0020, 32'h0400, 32'h0800, 32'h0cff, 32'h10ff, 32'h1800};
    foreach (model_q[i]) begin
      acc(1'b0, model_q[i][15:8], 8'h00);
      `CHK("reset value", model_q[i][7:0], q)
    end
    acc(1'b1, 8'h00, 8'h30);
    repeat (20) @(posedge clk_in);
    cnt(v);
    `CHK("halt and clear", 16'h0000, v)
    acc(1'b0, 8'h00, 8'h00);
    `CHK("clear bit reads", 8'h20, q)
    $display("done: reset");
    for (int k = 0; k < 7; k++) begin
      acc(1'b1, 8'h00, {5'h06, k[2:0]});
      acc(1'b1, 8'h00, {5'h00, k[2:0]});
      repeat (512) @(posedge clk_in);
      acc(1'b1, 8'h00, 8'h20);
      cnt(v);
      w = 515 >> k;
      `CHK("prescale", 1'b1, (v + 3 >= w && v <= w + 3))
      cnt(p);
      `CHK("halted", v, p)
    end
    $display("done: prescaler");
    acc(1'b1, 8'h00, 8'h10);
    acc(1'b0, `MTC_OFF_CNT_HI, 8'h00);
    v[15:8] = q;
    repeat (40) @(posedge clk_in);
    // second high read must not refresh the held low byte
    acc(1'b0, `MTC_OFF_CNT_HI, 8'h00);
    acc(1'b0, `MTC_OFF_CNT_LO, 8'h00);
    v[7:0] = q;
    cnt(p);
    w = p - v;
    `CHK("latched low", 1'b1, (w >= 40 && w < 64))
    $display("done: latch");
    seed = lfsr(seed);
    per = {11'h0, seed[4:0]} + 16'h0008;
    acc(1'b1, 8'h00, 8'h30);
    acc(1'b1, `MTC_OFF_PER_HI, 8'h00);
    acc(1'b1, `MTC_OFF_PER_LO, per[7:0]);
    acc(1'b1, 8'h00, 8'h40);
    repeat (60) @(posedge clk_in);
    `CHK("ovf request", 1'b1, ovf_irq)
    acc(1'b1, 8'h00, 8'hc0);
    acc(1'b0, 8'h00, 8'h00);
    `CHK("one kept flag", 8'hc0, q)
    repeat (80) @(posedge clk_in);
    acc(1'b1, 8'h00, 8'h40);
    acc(1'b0, 8'h00, 8'h00);
    `CHK("voided clear", 8'hc0, q)
    @(posedge clk_in) wmode <= 1'b1;
    acc(1'b0, 8'h00, 8'h00);
    `CHK("wait read", 8'h00, q)
    acc(1'b1, 8'h00, 8'h27);
    `CHK("wake", 1'b1, wake)
    @(posedge clk_in) wmode <= 1'b0;
    acc(1'b0, 8'h00, 8'h00);
    `CHK("wait write ignored", 8'hc0, q)
    acc(1'b1, 8'h00, 8'he0);
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b1, 8'h00, 8'h60);
    acc(1'b0, 8'h00, 8'h00);
    `CHK("flag cleared", 8'h60, q)
    `CHK("request dropped", 1'b0, ovf_irq)
    acc(1'b1, 8'h00, 8'h30);
    acc(1'b1, `MTC_OFF_PER_HI, 8'h00);
    acc(1'b1, 8'h00, 8'h00);
    repeat (100) @(posedge clk_in);
    acc(1'b0, 8'h00, 8'h00);
    `CHK("overflow held off", 8'h00, q)
    acc(1'b1, `MTC_OFF_PER_LO, per[7:0]);
    repeat (100) @(posedge clk_in);
    acc(1'b0, 8'h00, 8'h00);
    `CHK("overflow again", 8'h80, q)
    $display("done: overflow");
    acc(1'b1, 8'h00, 8'h30);
    acc(1'b1, `MTC_OFF_PER_HI, 8'hff);
    acc(1'b1, `MTC_OFF_PER_LO, 8'hff);
    acc(1'b1, 8'h00, 8'h00);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_in);
      brk   <= j[0];
      smode <= !j[0];
      cnt(v);
      repeat (30) @(posedge clk_in);
      cnt(p);
      `CHK("frozen", v, p)
      @(posedge clk_in);
      brk   <= 1'b0;
      smode <= 1'b0;
      repeat (30) @(posedge clk_in);
      cnt(p);
      `CHK("resumed", 1'b1, (p > v))
    end
    $display("done: stop and break");
    acc(1'b1, 8'h00, 8'h37);
    // select lands at the release edge, the pin flag one edge later
    repeat (2) @(posedge clk_in);
    `CHK("pin input", 1'b1, ext_in)
    u_mtc_pin_model.pulse_ext(3);
    acc(1'b1, 8'h00, 8'h07);
    seed = lfsr(seed);
    u_mtc_pin_model.pulse_ext(int'(seed[3:0]) + 1);
    acc(1'b1, 8'h00, 8'h27);
    cnt(v);
    `CHK("pin edges", {12'h0, seed[3:0]} + 16'h0001, v)
    $display("done: count pin");
    acc(1'b1, 8'h00, 8'h30);
    for (int i = 0; i < 6; i++) begin
      a = 8'(8'h20 + 4 * i);
      acc(1'b1, a, 8'h44);
      u_mtc_pin_model.pulse_pin(i);
      acc(1'b0, a, 8'h00);
      `CHK("halt blocks capture", 8'h44, q)
      acc(1'b1, 8'h00, 8'h00);
      u_mtc_pin_model.pulse_pin(i);
      acc(1'b0, a, 8'h00);
      `CHK("capture flag", 8'hc4, q)
      `CHK("channel request", 1'b1, ch_irq[i])
      acc(1'b1, a, 8'h04);
      acc(1'b0, a, 8'h00);
      `CHK("channel flag cleared", 8'h04, q)
      acc(1'b1, 8'h00, 8'h30);
    end
    $display("done: channels");
    acc(1'b1, 8'h00, 8'h30);
    acc(1'b1, 8'h20, 8'h18);
    acc(1'b1, `MTC_OFF_CH_VHI, 8'h00);
    acc(1'b1, `MTC_OFF_CH_VLO, 8'h10);
    `CHK("compare drive", 2'b11, {poe[0], pout[0]})
    acc(1'b1, 8'h00, 8'h00);
    repeat (40) @(posedge clk_in);
    `CHK("compare clear", 2'b10, {poe[0], pout[0]})
    acc(1'b0, 8'h20, 8'h00);
    `CHK("compare flag", 8'h98, q)
    $display("done: compare");
    give_verdict();
  end
endmodule
bind mtc_core mtc_core_monitor #(.CH_N(CH_N)) u_mtc_core_monitor (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .wait_mode_in(wait_mode_in),
  .ext_clock_is_input_out(ext_clock_is_input_out), .overflow_irq_out(overflow_irq_out),
  .channel_irq_out(channel_irq_out), .wake_out(wake_out));
